// File: inc/pfq_pkg.sv
`default_nettype none
package pfq_pkg;
    // Bus geometry.
    localparam int unsigned DW = 32;
    localparam int unsigned AW = 8;
    // Register byte offsets.
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_PRESET = 8'h04;
    localparam logic [7:0] A_ACC = 8'h08;
    localparam logic [7:0] A_RATE = 8'h0C;
    localparam logic [7:0] A_QPOS = 8'h10;
    localparam logic [7:0] A_FMINW = 8'h14;
    localparam logic [7:0] A_FLO = 8'h18;
    localparam logic [7:0] A_FHI = 8'h1C;
    localparam logic [7:0] A_FSAFE = 8'h20;
    localparam logic [7:0] A_FVAL = 8'h24;
    localparam logic [7:0] A_PNUM = 8'h28;
    localparam logic [7:0] A_PDIV = 8'h2C;
    localparam logic [7:0] A_PREM = 8'h30;
    localparam logic [7:0] A_ISTAT = 8'h34;
    localparam logic [7:0] A_IMASK = 8'h38;
    localparam logic [7:0] A_STAT = 8'h3C;
    // Control register bits.
    localparam int unsigned C_RESET = 0;
    localparam int unsigned C_PACT = 1;
    localparam int unsigned C_HOLD = 2;
    localparam int unsigned C_QZERO = 3;
    localparam int unsigned C_START = 4;
    localparam int unsigned C_Q4X = 5;
    localparam int unsigned CTRL_W = 6;
    // Interrupt status and mask bits.
    localparam int unsigned I_PRESET = 0;
    localparam int unsigned I_OVF = 1;
    localparam int unsigned I_FFAIL = 2;
    localparam int unsigned I_PDONE = 3;
    localparam int unsigned I_QERR = 4;
    localparam int unsigned IRQ_W = 5;
    // Status register bits.
    localparam int unsigned S_PRESET = 0;
    localparam int unsigned S_OVF = 1;
    localparam int unsigned S_FAIL = 2;
    localparam int unsigned S_FFAIL = 3;
    localparam int unsigned S_QDIR = 4;
    localparam int unsigned S_PBUSY = 5;
    // Reset values.
    localparam logic [31:0] CTRL_RST = 32'h0000_0020;
    localparam logic [31:0] PRESET_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] FMINW_RST = 32'h0000_0004;
    localparam logic [31:0] FLO_RST = 32'h0000_0000;
    localparam logic [31:0] FHI_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] FSAFE_RST = 32'h0000_0000;
    localparam logic [31:0] PDIV_RST = 32'h0000_0063;
    // Measurement window for rate and frequency.
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WIN_US = 1000;
    localparam int unsigned WIN_CYC = WIN_US * CLK_MHZ;
    // Pin synchroniser order.
    localparam int unsigned P_A = 0;
    localparam int unsigned P_B = 1;
    localparam int unsigned P_Z = 2;
    localparam int unsigned P_PULSE = 3;
    localparam int unsigned P_FREQ = 4;
    localparam int unsigned NPIN = 5;
    typedef enum logic [1:0] {PO_IDLE, PO_HIGH, PO_LOW} pfq_po_state_t;
endpackage : pfq_pkg
`default_nettype wire

// File: inc/pfq_qd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfq_qd_if;
    logic a;
    logic b;
    logic mode4x;
    logic zero;
    logic signed [31:0] pos;
    logic dir;
    logic err;
    modport dec (input a, input b, input mode4x, input zero, output pos, output dir, output err);
    modport ctl (output a, output b, output mode4x, output zero, input pos, input dir, input err);
endinterface : pfq_qd_if
`default_nettype wire

// File: rtl/pfq_qdec.sv
`timescale 1ns/1ps
`default_nettype none
module pfq_qdec (
    input wire logic pclk,
    input wire logic presetn,
    pfq_qd_if.dec qd
);
    logic [1:0] prev_q;
    logic [1:0] cur;
    logic signed [31:0] pos_q;
    logic dir_q;
    logic err_q;
    logic fwd;
    logic rev;

    assign cur = {qd.a, qd.b};

    // Classify the transition; A leading B walks 00,10,11,01 forward.
    always_comb begin
        fwd = 1'b0;
        rev = 1'b0;
        unique case ({prev_q, cur})
            4'h2, 4'hB, 4'hD, 4'h4: fwd = 1'b1; // see [R3]
            4'h1, 4'h7, 4'hE, 4'h8: rev = 1'b1; // see [R3]
            default: ;
        endcase
        // In single mode only the rising A edge counts, one bar per cycle.
        if (!qd.mode4x) begin
            fwd = fwd && (prev_q == 2'h0); // see [R2]
            rev = rev && (prev_q == 2'h1); // see [R2]
        end
    end

    // Position, direction and a sticky flag for an impossible double step.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 2'h0;
            pos_q <= 32'sh0;
            dir_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            prev_q <= cur;
            if (qd.zero) begin
                pos_q <= 32'sh0; // see [R4]
                err_q <= 1'b0;
            end else if (fwd) begin
                pos_q <= pos_q + 32'sh1; // see [R5]
                dir_q <= 1'b0;
            end else if (rev) begin
                pos_q <= pos_q - 32'sh1; // see [R5]
                dir_q <= 1'b1;
            end
            // Both channels moving at once breaks the quarter-cycle offset.
            if (!qd.zero && (prev_q ^ cur) == 2'h3) begin
                err_q <= 1'b1; // see [R1]
            end
        end
    end

    assign qd.pos = pos_q;
    assign qd.dir = dir_q;
    assign qd.err = err_q;

    step_4x_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
        (qd.mode4x && fwd && !qd.zero) |=> (pos_q == $past(pos_q) + 32'sh1) && !dir_q)
        else $error("position did not advance on a forward quadrature step");
endmodule : pfq_qdec
`default_nettype wire

// File: rtl/pfq_channel.sv
// What this block does
// [R1] Encoder gives A and B quarter-cycle apart.
// [R2] Count rising edges as encoder bars passing.
// [R3] Direction from which channel leads.
// [R4] Signed position from a zero marker.
// [R5] Decode all four states for 4X resolution.
// [R6] Accumulate pulses, readable by software.
// [R7] Software supplies preset, reset, action, hold.
// [R8] Flag when count reaches preset.
// [R9] Flag overflow and report channel failure.
// [R10] Rate is pulses divided by window time; the code reports the raw pulse count of each window.
// [R11] Ignore frequency pulses below minimum width.
// [R12] Out-of-range frequency gives failsafe and failure.
// [R13] Start sends exactly the requested pulse count.
// [R14] Output pulse frequency is selectable.
// [R15] Report pulses still to send.
// [R16] Hold freezes count; reset clears count, flag.
`timescale 1ns/1ps
`default_nettype none
module pfq_channel #(
    parameter int unsigned WIN_CYCLES = pfq_pkg::WIN_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic quad_a_in,
    input wire logic quad_b_in,
    input wire logic quad_z_in,
    input wire logic pulse_in,
    input wire logic freq_in,
    output logic pulse_out,
    output logic irq
);
    logic [pfq_pkg::NPIN-1:0] pin_raw;
    logic [pfq_pkg::NPIN-1:0] s1_q;
    logic [pfq_pkg::NPIN-1:0] s2_q;
    logic pulse_prev_q;
    logic freq_prev_q;
    logic [pfq_pkg::CTRL_W-1:0] ctrl_q;
    logic [31:0] preset_q, acc_q, rate_q, rate_cnt_q, win_cnt_q;
    logic [31:0] minw_q, flo_q, fhi_q, fsafe_q, fval_q, fw_q, fcnt_q;
    logic [31:0] pnum_q, pdiv_q, prem_q, pdiv_cnt_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_val;
    logic [pfq_pkg::IRQ_W-1:0] istat_q, imask_q, ev;
    logic preset_flag_q, ovf_q, ffail_q, pulse_out_q, pslverr_q, rd_fail_seen;
    logic setup, wr_en, addr_ok, acc_clr, start_cmd, win_tick;
    logic pulse_rise, cnt_step, freq_fall, freq_ok, fin_range, wr_ctrl;
    logic [32:0] acc_inc;
    pfq_pkg::pfq_po_state_t po_state_q;
    pfq_qd_if qd ();

    // Every pin is foreign to pclk, so each passes two flip-flops first.
    assign pin_raw = {freq_in, pulse_in, quad_z_in, quad_b_in, quad_a_in};
    for (genvar g = 0; g < pfq_pkg::NPIN; g++) begin : g_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
            end else begin
                s1_q[g] <= pin_raw[g];
                s2_q[g] <= s1_q[g];
            end
        end
    end

    // Edge detection looks only at the second synchroniser stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_prev_q <= 1'b0;
            freq_prev_q <= 1'b0;
        end else begin
            pulse_prev_q <= s2_q[pfq_pkg::P_PULSE];
            freq_prev_q <= s2_q[pfq_pkg::P_FREQ];
        end
    end

    // Zero-wait APB slave: read data is caught in the setup cycle.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= pfq_pkg::A_STAT);
    assign wr_ctrl = wr_en && (paddr == pfq_pkg::A_CTRL);
    assign acc_clr = wr_ctrl && pwdata[pfq_pkg::C_RESET]; // see [R7]
    assign start_cmd = wr_ctrl && pwdata[pfq_pkg::C_START];

    // Read multiplexer; unmapped words read zero.
    always_comb begin
        rd_val = 32'h0;
        unique case (paddr)
            pfq_pkg::A_CTRL: rd_val = {26'h0, ctrl_q};
            pfq_pkg::A_PRESET: rd_val = preset_q;
            pfq_pkg::A_ACC: rd_val = acc_q;
            pfq_pkg::A_RATE: rd_val = rate_q;
            pfq_pkg::A_QPOS: rd_val = qd.pos;
            pfq_pkg::A_FMINW: rd_val = minw_q;
            pfq_pkg::A_FLO: rd_val = flo_q;
            pfq_pkg::A_FHI: rd_val = fhi_q;
            pfq_pkg::A_FSAFE: rd_val = fsafe_q;
            pfq_pkg::A_FVAL: rd_val = fval_q;
            pfq_pkg::A_PNUM: rd_val = pnum_q;
            pfq_pkg::A_PDIV: rd_val = pdiv_q;
            pfq_pkg::A_PREM: rd_val = prem_q;
            pfq_pkg::A_ISTAT: rd_val = {27'h0, istat_q};
            pfq_pkg::A_IMASK: rd_val = {27'h0, imask_q};
            pfq_pkg::A_STAT: rd_val = {26'h0, po_state_q != pfq_pkg::PO_IDLE, qd.dir,
                ffail_q, ovf_q | qd.err, ovf_q, preset_flag_q};
            default: rd_val = 32'h0;
        endcase
    end

    // Answer register, loaded once per transfer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0 : rd_val;
            pslverr_q <= !addr_ok;
        end
    end

    // Software-written configuration; command bits do not stay stored.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= pfq_pkg::CTRL_RST[pfq_pkg::CTRL_W-1:0];
            preset_q <= pfq_pkg::PRESET_RST;
            minw_q <= pfq_pkg::FMINW_RST;
            flo_q <= pfq_pkg::FLO_RST;
            fhi_q <= pfq_pkg::FHI_RST;
            fsafe_q <= pfq_pkg::FSAFE_RST;
            pnum_q <= 32'h0;
            pdiv_q <= pfq_pkg::PDIV_RST;
            imask_q <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                pfq_pkg::A_CTRL: ctrl_q <= pwdata[pfq_pkg::CTRL_W-1:0] & 6'h26; // see [R7]
                pfq_pkg::A_PRESET: preset_q <= pwdata; // see [R7]
                pfq_pkg::A_FMINW: minw_q <= pwdata;
                pfq_pkg::A_FLO: flo_q <= pwdata;
                pfq_pkg::A_FHI: fhi_q <= pwdata;
                pfq_pkg::A_FSAFE: fsafe_q <= pwdata;
                pfq_pkg::A_PNUM: pnum_q <= pwdata;
                pfq_pkg::A_PDIV: pdiv_q <= pwdata; // see [R14]
                pfq_pkg::A_IMASK: imask_q <= pwdata[pfq_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Quadrature decoder hookup; the marker pin and the command both zero it.
    assign qd.a = s2_q[pfq_pkg::P_A];
    assign qd.b = s2_q[pfq_pkg::P_B];
    assign qd.mode4x = ctrl_q[pfq_pkg::C_Q4X];
    assign qd.zero = s2_q[pfq_pkg::P_Z] || (wr_ctrl && pwdata[pfq_pkg::C_QZERO]); // see [R4]
    pfq_qdec u_qdec (
        .pclk(pclk),
        .presetn(presetn),
        .qd(qd)
    );

    // Pulse accumulator with hold, preset action and overflow wrap.
    assign pulse_rise = s2_q[pfq_pkg::P_PULSE] && !pulse_prev_q;
    assign cnt_step = pulse_rise && !ctrl_q[pfq_pkg::C_HOLD] && !acc_clr; // see [R16]
    assign acc_inc = {1'b0, acc_q} + 33'h1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 32'h0;
            preset_flag_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (acc_clr) begin
            acc_q <= 32'h0; // see [R16]
            preset_flag_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (cnt_step) begin
            acc_q <= acc_inc[31:0]; // see [R6]
            if (acc_inc[32]) begin
                ovf_q <= 1'b1; // see [R9]
            end
            if (acc_inc[31:0] >= preset_q) begin
                preset_flag_q <= 1'b1; // see [R8]
                // Preset action restarts the count so batches repeat.
                if (ctrl_q[pfq_pkg::C_PACT]) begin
                    acc_q <= 32'h0;
                end
            end
        end
    end

    // Fixed measurement window shared by rate and frequency.
    assign win_tick = (win_cnt_q == 32'(WIN_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_q <= 32'h0;
        end else begin
            win_cnt_q <= win_tick ? 32'h0 : win_cnt_q + 32'h1;
        end
    end

    // Rate counts every pulse, held or not, over a window of known length.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt_q <= 32'h0;
            rate_q <= 32'h0;
        end else if (win_tick) begin
            rate_q <= rate_cnt_q + {31'h0, pulse_rise}; // see [R10]
            rate_cnt_q <= 32'h0;
        end else if (pulse_rise) begin
            rate_cnt_q <= rate_cnt_q + 32'h1;
        end
    end

    // Frequency input: high time is measured and short pulses are dropped.
    assign freq_fall = !s2_q[pfq_pkg::P_FREQ] && freq_prev_q;
    assign freq_ok = freq_fall && (fw_q >= minw_q); // see [R11]
    assign fin_range = (fcnt_q >= flo_q) && (fcnt_q <= fhi_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_q <= 32'h0;
        end else if (!s2_q[pfq_pkg::P_FREQ]) begin
            fw_q <= 32'h0;
        end else if (fw_q != 32'hFFFF_FFFF) begin
            fw_q <= fw_q + 32'h1;
        end
    end

    // A pulse ending on the window edge is dropped; one pulse of error at most.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_q <= 32'h0;
            fval_q <= pfq_pkg::FSAFE_RST;
            ffail_q <= 1'b0;
        end else if (win_tick) begin
            fcnt_q <= 32'h0;
            fval_q <= fin_range ? fcnt_q : fsafe_q; // see [R12]
            ffail_q <= !fin_range;
        end else if (freq_ok) begin
            fcnt_q <= fcnt_q + 32'h1;
        end
    end

    // Pulse train: each half period lasts the divider value plus one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            po_state_q <= pfq_pkg::PO_IDLE;
            pulse_out_q <= 1'b0;
            prem_q <= 32'h0;
            pdiv_cnt_q <= 32'h0;
        end else begin
            unique case (po_state_q)
                pfq_pkg::PO_IDLE: begin
                    // Starting a zero-length train does nothing.
                    if (start_cmd && pnum_q != 32'h0) begin
                        prem_q <= pnum_q; // see [R13]
                        pulse_out_q <= 1'b1;
                        pdiv_cnt_q <= 32'h0;
                        po_state_q <= pfq_pkg::PO_HIGH;
                    end
                end
                pfq_pkg::PO_HIGH: begin
                    if (pdiv_cnt_q == pdiv_q) begin
                        pulse_out_q <= 1'b0;
                        pdiv_cnt_q <= 32'h0;
                        po_state_q <= pfq_pkg::PO_LOW;
                    end else begin
                        pdiv_cnt_q <= pdiv_cnt_q + 32'h1; // see [R14]
                    end
                end
                pfq_pkg::PO_LOW: begin
                    if (pdiv_cnt_q == pdiv_q) begin
                        prem_q <= prem_q - 32'h1; // see [R15]
                        pdiv_cnt_q <= 32'h0;
                        if (prem_q == 32'h1) begin
                            po_state_q <= pfq_pkg::PO_IDLE; // see [R13]
                        end else begin
                            pulse_out_q <= 1'b1;
                            po_state_q <= pfq_pkg::PO_HIGH;
                        end
                    end else begin
                        pdiv_cnt_q <= pdiv_cnt_q + 32'h1;
                    end
                end
            endcase
        end
    end
    assign pulse_out = pulse_out_q;

    // Events: a set in the same cycle as a write-one-to-clear survives.
    always_comb begin
        ev = '0;
        ev[pfq_pkg::I_PRESET] = cnt_step && !preset_flag_q && (acc_inc[31:0] >= preset_q);
        ev[pfq_pkg::I_OVF] = cnt_step && acc_inc[32];
        ev[pfq_pkg::I_FFAIL] = win_tick && !fin_range;
        ev[pfq_pkg::I_PDONE] = (po_state_q == pfq_pkg::PO_LOW) && (pdiv_cnt_q == pdiv_q)
            && (prem_q == 32'h1);
        ev[pfq_pkg::I_QERR] = qd.err;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_q <= '0;
        end else if (wr_en && paddr == pfq_pkg::A_ISTAT) begin
            istat_q <= (istat_q & ~pwdata[pfq_pkg::IRQ_W-1:0]) | ev;
        end else begin
            istat_q <= istat_q | ev;
        end
    end
    assign irq = |(istat_q & imask_q);

    hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R16]
        (ctrl_q[pfq_pkg::C_HOLD] && !acc_clr) |=> $stable(acc_q))
        else $error("accumulator moved while held");

    reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R16]
        acc_clr |=> (acc_q == 32'h0) && !preset_flag_q && !ovf_q)
        else $error("reset request did not clear count and flags");

    count_step_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
        (cnt_step && !ctrl_q[pfq_pkg::C_PACT]) |=> (acc_q == $past(acc_q) + 32'h1))
        else $error("accumulator did not count the pulse");

    preset_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R8]
        (cnt_step && acc_inc[31:0] >= preset_q)
        |=> preset_flag_q && (istat_q[pfq_pkg::I_PRESET] || $past(preset_flag_q)))
        else $error("preset reached but flag not raised");

    overflow_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R9]
        (cnt_step && acc_q == 32'hFFFF_FFFF) |=> ovf_q && rd_fail_seen)
        else $error("overflow not flagged");

    freq_fail_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R12]
        (win_tick && !fin_range) |=> ffail_q && (fval_q == $past(fsafe_q)))
        else $error("out of range frequency did not give failsafe");

    pout_rem_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R15]
        (po_state_q == pfq_pkg::PO_LOW && pdiv_cnt_q == pdiv_q)
        |=> (prem_q == $past(prem_q) - 32'h1))
        else $error("remaining count not reduced after a pulse");

    pout_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // see [R13]
        (po_state_q == pfq_pkg::PO_IDLE) |-> !pulse_out && (prem_q == 32'h0))
        else $error("output active with no train running");

    assign rd_fail_seen = ovf_q | qd.err;
endmodule : pfq_channel
`default_nettype wire

// File: tb/pfq_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfq_src_model (
    input wire logic clk,
    output logic qa,
    output logic qb,
    output logic qz,
    output logic pin,
    output logic fin
);
    logic [1:0] ph;

    // Every pin starts low, and every later change comes just after a clock edge.
    initial begin
        ph = 2'h0;
        {qa, qb, qz, pin, fin} = 5'h00;
    end

    // A Gray walk; forward puts channel A a quarter cycle ahead of channel B.
    task automatic quad(input int cnt, input bit fwd);
        for (int i = 0; i < cnt; i++) begin
            repeat (4) @(posedge clk);
            ph = fwd ? ph + 2'h1 : ph - 2'h1;
            qa <= ph[1] ^ ph[0];
            qb <= ph[1];
        end
    endtask : quad

    // The marker is a short level pulse, as a real index track gives.
    task automatic zero();
        @(posedge clk);
        qz <= 1'b1;
        repeat (4) @(posedge clk);
        qz <= 1'b0;
    endtask : zero

    // Pulses hi cycles wide in a period of per cycles, on the count or frequency pin.
    task automatic train(input bit sel, input int cnt, input int hi, input int per);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            if (sel) fin <= 1'b1; else pin <= 1'b1;
            repeat (hi) @(posedge clk);
            if (sel) fin <= 1'b0; else pin <= 1'b0;
            repeat (per - hi - 1) @(posedge clk);
        end
    endtask : train
endmodule : pfq_src_model
`default_nettype wire

// File: tb/pulse_freq_quadrature_channel_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_freq_quadrature_channel_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic qa, qb, qz, pin, fin, pulse_out, po_q, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v, base, hi_cnt, hi_len, rises;
    int num_errors = 0;
    int total_checks = 0;
    int n;

    // A short window keeps the rate and frequency runs brief.
    pfq_channel #(.WIN_CYCLES(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .quad_a_in(qa), .quad_b_in(qb), .quad_z_in(qz),
        .pulse_in(pin), .freq_in(fin), .pulse_out(pulse_out), .irq(irq));
    pfq_src_model src (.clk(pclk), .qa(qa), .qb(qb), .qz(qz), .pin(pin), .fin(fin));

    // Clock of 5 ns period.
    always #2.5 pclk = ~pclk;

    // Counts rising edges of the train and keeps the width of its last high phase.
    always @(posedge pclk) begin
        po_q <= pulse_out;
        if (pulse_out && !po_q) rises <= rises + 32'h1;
        if (pulse_out) begin
            hi_cnt <= hi_cnt + 32'h1;
        end else if (hi_cnt != 32'h0) begin
            hi_len <= hi_cnt;
            hi_cnt <= 32'h0;
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One transfer, then an idle cycle so psel never changes twice in a time step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        int k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        apb(1'b1, a, d, r, x);
    endtask : wr

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic x;
        apb(1'b0, a, 32'h0, r, x);
        check(nm, r, exp);
    endtask : rc

    // Reset, then quadrature, accumulator, rate, frequency and pulse output in turn.
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 45'h0;
        {po_q, rises, hi_cnt, hi_len} = 97'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("ctrl", pfq_pkg::A_CTRL, pfq_pkg::CTRL_RST);
        rc("pdiv", pfq_pkg::A_PDIV, pfq_pkg::PDIV_RST);
        apb(1'b0, 8'h40, 32'h0, v, e);
        check("slverr", {31'h0, e}, 32'h1);
        src.quad(8, 1'b1);
        repeat (4) @(posedge pclk);
        rc("qpos", pfq_pkg::A_QPOS, 32'h0000_0008);
        src.quad(3, 1'b0);
        repeat (4) @(posedge pclk);
        rc("qpos", pfq_pkg::A_QPOS, 32'h0000_0005);
        apb(1'b0, pfq_pkg::A_STAT, 32'h0, v, e);
        check("qdir", v & 32'h0000_0010, 32'h0000_0010);
        src.zero();
        repeat (4) @(posedge pclk);
        rc("qpos", pfq_pkg::A_QPOS, 32'h0);
        wr(pfq_pkg::A_CTRL, 32'h0000_0000);
        src.quad(8, 1'b1);
        repeat (4) @(posedge pclk);
        rc("qpos", pfq_pkg::A_QPOS, 32'h0000_0002);
        wr(pfq_pkg::A_CTRL, 32'h0000_0028);
        src.quad(2, 1'b0);
        repeat (4) @(posedge pclk);
        rc("qpos", pfq_pkg::A_QPOS, 32'hFFFF_FFFE);
        wr(pfq_pkg::A_PRESET, 32'h0000_0003);
        wr(pfq_pkg::A_IMASK, 32'h0000_0001);
        wr(pfq_pkg::A_CTRL, 32'h0000_0021);
        src.train(1'b0, 3, 4, 8);
        repeat (4) @(posedge pclk);
        rc("acc", pfq_pkg::A_ACC, 32'h0000_0003);
        apb(1'b0, pfq_pkg::A_STAT, 32'h0, v, e);
        check("preset", v & 32'h0000_0001, 32'h0000_0001);
        check("irq", {31'h0, irq}, 32'h1);
        wr(pfq_pkg::A_CTRL, 32'h0000_0021);
        rc("acc", pfq_pkg::A_ACC, 32'h0);
        // The direction of the last reverse move is not touched by the reset request.
        rc("stat", pfq_pkg::A_STAT, 32'h0000_0010);
        wr(pfq_pkg::A_ISTAT, 32'h0000_0001);
        check("irq", {31'h0, irq}, 32'h0);
        wr(pfq_pkg::A_CTRL, 32'h0000_0024);
        src.train(1'b0, 2, 4, 8);
        repeat (4) @(posedge pclk);
        rc("acc", pfq_pkg::A_ACC, 32'h0);
        // Preset action on: 40 pulses against a preset of 3 leave a count of 1.
        wr(pfq_pkg::A_CTRL, 32'h0000_0022);
        wr(pfq_pkg::A_IMASK, 32'h0);
        wr(pfq_pkg::A_FLO, 32'h0000_0002);
        wr(pfq_pkg::A_FHI, 32'h0000_0006);
        wr(pfq_pkg::A_FSAFE, 32'h0000_0055);
        fork
            src.train(1'b0, 40, 4, 8);
            src.train(1'b1, 20, 6, 16);
            begin
                repeat (200) @(posedge pclk);
                rc("rate", pfq_pkg::A_RATE, 32'h0000_0008);
                rc("fval", pfq_pkg::A_FVAL, 32'h0000_0004);
            end
        join
        rc("acc", pfq_pkg::A_ACC, 32'h0000_0001);
        fork
            src.train(1'b1, 20, 2, 16);
            begin
                repeat (200) @(posedge pclk);
                rc("fval", pfq_pkg::A_FVAL, 32'h0000_0055);
                apb(1'b0, pfq_pkg::A_STAT, 32'h0, v, e);
                check("ffail", v & 32'h0000_0008, 32'h0000_0008);
                check("irq", {31'h0, irq}, 32'h0);
            end
        join
        wr(pfq_pkg::A_IMASK, 32'h0000_0004);
        check("irq", {31'h0, irq}, 32'h1);
        for (int p = 1; p < 5; p += 2) begin
            wr(pfq_pkg::A_PDIV, 32'(p));
            wr(pfq_pkg::A_PNUM, 32'h0000_0003);
            base = rises;
            wr(pfq_pkg::A_CTRL, 32'h0000_0030);
            rc("prem", pfq_pkg::A_PREM, 32'h0000_0003);
            n = 0;
            do begin
                apb(1'b0, pfq_pkg::A_STAT, 32'h0, v, e);
                n++;
            end while (v[pfq_pkg::S_PBUSY] !== 1'b0 && n < 100);
            if (v[pfq_pkg::S_PBUSY] !== 1'b0) begin
                num_errors++;
                print_verdict();
            end
            check("pulses", rises - base, 32'h0000_0003);
            check("high", hi_len, 32'(p + 1));
            rc("prem", pfq_pkg::A_PREM, 32'h0);
        end
        apb(1'b0, pfq_pkg::A_ISTAT, 32'h0, v, e);
        check("pdone", v & 32'h0000_0008, 32'h0000_0008);
        print_verdict();
    end
endmodule : pulse_freq_quadrature_channel_tb
`default_nettype wire
